// ---- rtl/ppr_pkg.sv ----
/*
 * ppr_pkg: register map, field layout, reset values and pin positions of
 * the peripheral pin router.
 * Assumes one peripheral clock and a byte-wide register port driven by the cpu.
 */
// Summary of operation
// - event output d moves from port d pin 2 to pin 7 when its bit is set.
// - event output c moves from port c pin 2 to pin 7 when its bit is set.
// - event output a moves from port a pin 2 to pin 7 when its bit is set.
// - logic table bits move outputs of ports a, c, d, f from pin 3 to 6.
// - transceiver field: 0 default, 1 alternate, 3 disconnected, 2 reserved.
// - transceivers 0 and 1 use pins 3..0 of ports a, c, alternate pins 7..4.
// - transceiver 2 on f 3..0 or 6..4; transceiver 3 on b 3..0 or 5..4.
// - two-wire lines on port a pins 3,2 for 0 and 1, port c for 2.
// - dual mode client pair on port c for 0, port f for 1 and 2.
// - serial peripheral on a 7..4, c 3..0, e 3..0; value 3 unconnected.
// - waveform timer outputs on pins 5..0 of ports a..f for values 0..5.
// - timer 3 output moves from port b pin 5 to port c pin 1.
// - timer 2 output moves from port c pin 0 to port b pin 4.
package ppr_pkg;
    localparam logic [7:0] EVENT_OUTPUT_ROUTE_OFS = 8'h00;
    localparam logic [7:0] LOGIC_TABLE_ROUTE_OFS = 8'h01;
    localparam logic [7:0] SERIAL_TRANSCEIVER_ROUTE_OFS = 8'h02;
    localparam logic [7:0] TWO_WIRE_AND_SPI_ROUTE_OFS = 8'h03;
    localparam logic [7:0] WAVEFORM_TIMER_ROUTE_OFS = 8'h04;
    localparam logic [7:0] CAPTURE_TIMER_ROUTE_OFS = 8'h05;
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    // writable bit masks; all other bits read zero
    localparam logic [7:0] EVENT_MASK = 8'h3f;
    localparam logic [7:0] LOGIC_TABLE_MASK = 8'h0f;
    localparam logic [7:0] TRANSCEIVER_MASK = 8'hff;
    localparam logic [7:0] TWO_WIRE_SPI_MASK = 8'h33;
    localparam logic [7:0] WAVEFORM_MASK = 8'h07;
    localparam logic [7:0] CAPTURE_MASK = 8'h0f;
    // field positions
    localparam int TWO_WIRE_POS = 4;
    localparam int SPI_POS = 0;
    localparam int CAPTURE_TIMER2_POS = 2;
    localparam int CAPTURE_TIMER3_POS = 3;
    localparam logic [5:0] EVENT_ALT_ALLOWED = 6'h0d;
    // two-bit route encodings
    localparam logic [1:0] ROUTE_DEFAULT = 2'h0;
    localparam logic [1:0] ROUTE_ALTERNATE_ONE = 2'h1;
    localparam logic [1:0] ROUTE_ALTERNATE_TWO = 2'h2;
    localparam logic [1:0] ROUTE_NONE = 2'h3;
    localparam logic [2:0] WAVEFORM_LAST_PORT = 3'h5;
    // port indices
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int NUM_PORTS = 6;
    // pin positions
    localparam int EVENT_DEFAULT_PIN = 2;
    localparam int EVENT_ALT_PIN = 7;
    localparam int TABLE_DEFAULT_PIN = 3;
    localparam int TABLE_ALT_PIN = 6;
    localparam int GROUP_LOW_BASE = 0;
    localparam int GROUP_HIGH_BASE = 4;
    localparam int TWO_WIRE_BASE = 2;
    localparam int TIMER3_DEFAULT_PIN = 5;
    localparam int TIMER3_ALT_PIN = 1;
    localparam int TIMER2_DEFAULT_PIN = 0;
    localparam int TIMER2_ALT_PIN = 4;
    localparam int TABLE_PORT [4] = '{PORT_A, PORT_C, PORT_D, PORT_F};
    localparam int XCVR_PORT [4] = '{PORT_A, PORT_C, PORT_F, PORT_B};
    localparam logic [3:0] XCVR_ALT_LANES [4] = '{4'hf, 4'hf, 4'h7, 4'h3};
    localparam logic [3:0] FULL_LANES = 4'hf;
endpackage : ppr_pkg

// ---- rtl/ppr_router.sv ----
/*
 * ppr_router: byte-wide route registers and the pin override matrix for
 * six ports of eight pins.
 * Assumes the port block obeys pinOwn, pinOut and pinOeN, and that pin levels
 * arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ps
module ppr_router
    import ppr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic [5:0] eventOut,
    input wire logic [3:0] tableOut,
    input wire logic [3:0][3:0] xcvrOut,
    input wire logic [3:0][3:0] xcvrOe,
    output logic [3:0][3:0] xcvrIn,
    input wire logic dualTwoWire,
    input wire logic [1:0] twoWireHostOeN,
    output logic [1:0] twoWireHostIn,
    input wire logic [1:0] twoWireClientOeN,
    output logic [1:0] twoWireClientIn,
    input wire logic [3:0] spiOut,
    input wire logic [3:0] spiOe,
    output logic [3:0] spiIn,
    input wire logic [5:0] waveOut,
    input wire logic timer2Out,
    input wire logic timer3Out,
    input wire logic [5:0][7:0] pinIn,
    output logic [5:0][7:0] pinOwn,
    output logic [5:0][7:0] pinOut,
    output logic [5:0][7:0] pinOeN
);
    logic [7:0] eventRoute_q;
    logic [7:0] tableRoute_q;
    logic [7:0] xcvrRoute_q;
    logic [7:0] twoWireSpiRoute_q;
    logic [7:0] waveRoute_q;
    logic [7:0] captureRoute_q;
    logic [7:0] regRdData_q;
    logic [7:0] regRdData_d;
    logic [5:0][7:0] pinMeta_q;
    logic [5:0][7:0] pinSync_q;

    wire selEvent = regAddr == EVENT_OUTPUT_ROUTE_OFS;
    wire selTable = regAddr == LOGIC_TABLE_ROUTE_OFS;
    wire selXcvr = regAddr == SERIAL_TRANSCEIVER_ROUTE_OFS;
    wire selTwoWireSpi = regAddr == TWO_WIRE_AND_SPI_ROUTE_OFS;
    wire selWave = regAddr == WAVEFORM_TIMER_ROUTE_OFS;
    wire selCapture = regAddr == CAPTURE_TIMER_ROUTE_OFS;
    wire [1:0] twoWireRoute = twoWireSpiRoute_q[TWO_WIRE_POS +: 2];
    wire [1:0] spiRoute = twoWireSpiRoute_q[SPI_POS +: 2];
    wire [2:0] waveSel = waveRoute_q[2:0];
    wire timer2Alt = captureRoute_q[CAPTURE_TIMER2_POS];
    wire timer3Alt = captureRoute_q[CAPTURE_TIMER3_POS];
    // reserved event alternates act as default so a stray one moves nothing
    wire [5:0] eventAlt = eventRoute_q[5:0] & EVENT_ALT_ALLOWED;

    // undefined bits never stored, so they read back as zero
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            eventRoute_q <= ROUTE_RESET;
            tableRoute_q <= ROUTE_RESET;
            xcvrRoute_q <= ROUTE_RESET;
            twoWireSpiRoute_q <= ROUTE_RESET;
            waveRoute_q <= ROUTE_RESET;
            captureRoute_q <= ROUTE_RESET;
        end
        else if (regWrStb)
        begin
            if (selEvent) eventRoute_q <= regWrData & EVENT_MASK;
            if (selTable) tableRoute_q <= regWrData & LOGIC_TABLE_MASK;
            if (selXcvr) xcvrRoute_q <= regWrData & TRANSCEIVER_MASK;
            if (selTwoWireSpi) twoWireSpiRoute_q <= regWrData & TWO_WIRE_SPI_MASK;
            if (selWave) waveRoute_q <= regWrData & WAVEFORM_MASK;
            if (selCapture) captureRoute_q <= regWrData & CAPTURE_MASK;
        end
    end

    always_comb
    begin
        regRdData_d = 8'h00;
        if (regRdStb)
        begin
            case (1'b1)
                selEvent: regRdData_d = eventRoute_q;
                selTable: regRdData_d = tableRoute_q;
                selXcvr: regRdData_d = xcvrRoute_q;
                selTwoWireSpi: regRdData_d = twoWireSpiRoute_q;
                selWave: regRdData_d = waveRoute_q;
                selCapture: regRdData_d = captureRoute_q;
                default: regRdData_d = 8'h00;
            endcase
        end
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge clock)
    begin
        if (rst)
            regRdData_q <= 8'h00;
        else
            regRdData_q <= regRdData_d;
    end
    assign regRdData = regRdData_q;

    // pins are asynchronous to the peripheral clock
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_sync
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    pinMeta_q[gp] <= 8'hff;
                    pinSync_q[gp] <= 8'hff;
                end
                else
                begin
                    pinMeta_q[gp] <= pinIn[gp];
                    pinSync_q[gp] <= pinMeta_q[gp];
                end
            end
        end
    endgenerate

    // later claims win on a clash; overlapping routes are a software fault
    always_comb
    begin
        int port;
        int base;
        logic [3:0] lanes;
        port = 0;
        base = 0;
        lanes = 4'h0;
        pinOwn = '0;
        pinOut = '0;
        pinOeN = '1;
        xcvrIn = '1;
        twoWireHostIn = 2'h3;
        twoWireClientIn = 2'h3;
        spiIn = 4'hf;

        // event outputs a, c, d have alternates
        for (int k = 0; k < NUM_PORTS; k++)
        begin
            base = eventAlt[k] ? EVENT_ALT_PIN : EVENT_DEFAULT_PIN;
            pinOwn[k][base] = 1'b1;
            pinOut[k][base] = eventOut[k];
            pinOeN[k][base] = 1'b0;
        end

        for (int k = 0; k < 4; k++)
        begin
            base = tableRoute_q[k] ? TABLE_ALT_PIN : TABLE_DEFAULT_PIN;
            pinOwn[TABLE_PORT[k]][base] = 1'b1;
            pinOut[TABLE_PORT[k]][base] = tableOut[k];
            pinOeN[TABLE_PORT[k]][base] = 1'b0;
        end

        for (int n = 0; n < 4; n++)
        begin
            port = XCVR_PORT[n];
            case (xcvrRoute_q[2 * n +: 2])
                ROUTE_DEFAULT:
                begin
                    base = GROUP_LOW_BASE;
                    lanes = FULL_LANES;
                end
                ROUTE_ALTERNATE_ONE:
                begin
                    base = GROUP_HIGH_BASE;
                    lanes = XCVR_ALT_LANES[n];
                end
                default:
                begin
                    base = GROUP_LOW_BASE;
                    lanes = 4'h0;
                end
            endcase
            for (int i = 0; i < 4; i++)
            begin
                if (lanes[i])
                begin
                    pinOwn[port][base + i] = 1'b1;
                    pinOut[port][base + i] = xcvrOut[n][i];
                    pinOeN[port][base + i] = ~xcvrOe[n][i];
                    xcvrIn[n][i] = pinSync_q[port][base + i];
                end
            end
        end

        // open drain: lines only ever pull low
        case (twoWireRoute)
            ROUTE_DEFAULT, ROUTE_ALTERNATE_ONE: port = PORT_A;
            ROUTE_ALTERNATE_TWO: port = PORT_C;
            default: port = -1;
        endcase
        if (port >= 0)
        begin
            for (int i = 0; i < 2; i++)
            begin
                pinOwn[port][TWO_WIRE_BASE + i] = 1'b1;
                pinOut[port][TWO_WIRE_BASE + i] = 1'b0;
                pinOeN[port][TWO_WIRE_BASE + i] = twoWireHostOeN[i];
                twoWireHostIn[i] = pinSync_q[port][TWO_WIRE_BASE + i];
            end
        end
        case (twoWireRoute)
            ROUTE_DEFAULT: port = PORT_C;
            ROUTE_ALTERNATE_ONE, ROUTE_ALTERNATE_TWO: port = PORT_F;
            default: port = -1;
        endcase
        if (dualTwoWire && port >= 0)
        begin
            for (int i = 0; i < 2; i++)
            begin
                pinOwn[port][TWO_WIRE_BASE + i] = 1'b1;
                pinOut[port][TWO_WIRE_BASE + i] = 1'b0;
                pinOeN[port][TWO_WIRE_BASE + i] = twoWireClientOeN[i];
                twoWireClientIn[i] = pinSync_q[port][TWO_WIRE_BASE + i];
            end
        end

        case (spiRoute)
            ROUTE_DEFAULT:
            begin
                port = PORT_A;
                base = GROUP_HIGH_BASE;
            end
            ROUTE_ALTERNATE_ONE:
            begin
                port = PORT_C;
                base = GROUP_LOW_BASE;
            end
            ROUTE_ALTERNATE_TWO:
            begin
                port = PORT_E;
                base = GROUP_LOW_BASE;
            end
            default:
            begin
                port = -1;
                base = GROUP_LOW_BASE;
            end
        endcase
        if (port >= 0)
        begin
            for (int i = 0; i < 4; i++)
            begin
                pinOwn[port][base + i] = 1'b1;
                pinOut[port][base + i] = spiOut[i];
                pinOeN[port][base + i] = ~spiOe[i];
                spiIn[i] = pinSync_q[port][base + i];
            end
        end

        // reserved selections leave the waveform timer on no pins
        if (waveSel <= WAVEFORM_LAST_PORT)
        begin
            for (int i = 0; i < 6; i++)
            begin
                pinOwn[waveSel][i] = 1'b1;
                pinOut[waveSel][i] = waveOut[i];
                pinOeN[waveSel][i] = 1'b0;
            end
        end

        port = timer3Alt ? PORT_C : PORT_B;
        base = timer3Alt ? TIMER3_ALT_PIN : TIMER3_DEFAULT_PIN;
        pinOwn[port][base] = 1'b1;
        pinOut[port][base] = timer3Out;
        pinOeN[port][base] = 1'b0;

        port = timer2Alt ? PORT_B : PORT_C;
        base = timer2Alt ? TIMER2_ALT_PIN : TIMER2_DEFAULT_PIN;
        pinOwn[port][base] = 1'b1;
        pinOut[port][base] = timer2Out;
        pinOeN[port][base] = 1'b0;
    end
endmodule : ppr_router

// ---- verification/ppr_router_sva.sv ----
/*
 * ppr_router_sva: bound assertions on the ppr_router ports.
 * Assumes one clock and synchronous active high rst.
 */
`timescale 1ns/1ps
module ppr_router_sva
    import ppr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic [5:0] eventOut,
    input wire logic timer3Out,
    input wire logic [5:0] waveOut,
    input wire logic [5:0][7:0] pinOwn,
    input wire logic [5:0][7:0] pinOut,
    input wire logic [5:0][7:0] pinOeN
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence wrAt(logic [7:0] a);
        regWrStb && regAddr == a;
    endsequence
    sequence rdAt(logic [7:0] a);
        regRdStb && regAddr == a;
    endsequence
    a_idle_read_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
        else $error("read data outside read cycle");
    a_table_readback: assert property (wrAt(LOGIC_TABLE_ROUTE_OFS) ##1
        rdAt(LOGIC_TABLE_ROUTE_OFS) |=> regRdData == ($past(regWrData, 2) & 8'h0f))
        else $error("table route readback");
    a_unmapped_zero: assert property (regRdStb && regAddr > 8'h05 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_event_d_alt: assert property (wrAt(EVENT_OUTPUT_ROUTE_OFS) |=>
        pinOwn[PORT_D][7] == $past(regWrData[3]) && (!pinOwn[PORT_D][7]
        || pinOut[PORT_D][7] == eventOut[PORT_D]))
        else $error("event d alternate pin");
    a_release_idle: assert property ((pinOut & ~pinOwn) == '0 && (pinOeN | pinOwn) == '1)
        else $error("unowned pin still driven");
    a_timer3_alt: assert property (wrAt(CAPTURE_TIMER_ROUTE_OFS) ##0 regWrData[3] |=>
        pinOut[PORT_C][1] == timer3Out && !pinOeN[PORT_C][1])
        else $error("timer 3 alternate pin");
    a_wave_port_d: assert property (wrAt(WAVEFORM_TIMER_ROUTE_OFS) ##0
        regWrData[2:0] == 3'h3 |=> pinOut[PORT_D][5:0] == waveOut)
        else $error("waveform outputs on port d");
    a_wave_hold: assert property (wrAt(WAVEFORM_TIMER_ROUTE_OFS) ##0
        regWrData[2:0] == 3'h3 ##1 (!regWrStb || regAddr != WAVEFORM_TIMER_ROUTE_OFS)
        |=> pinOut[PORT_D][5:0] == waveOut)
        else $error("waveform route not held");
endmodule : ppr_router_sva

bind ppr_router ppr_router_sva u_ppr_router_sva
(
    .clock, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .eventOut, .timer3Out, .waveOut, .pinOwn, .pinOut, .pinOeN
);

// ---- verification/ppr_pad_model.sv ----
/*
 * ppr_pad_model: board pads around the router.
 * Assumes undriven pads sit at a level chosen by the bench.
 */
`timescale 1ns/1ps
module ppr_pad_model
(
    input wire logic [5:0][7:0] pinOwn,
    input wire logic [5:0][7:0] pinOut,
    input wire logic [5:0][7:0] pinOeN,
    input wire logic [5:0][7:0] padLevel,
    output logic [5:0][7:0] pinIn
);
    // a pad driven by the router shows its value, else the board level
    wire logic [5:0][7:0] driven = pinOwn & ~pinOeN;
    assign pinIn = (driven & pinOut) | (~driven & padLevel);
endmodule : ppr_pad_model

// ---- verification/ppr_router_tb.sv ----
/*
 * ppr_router_tb: register and routing tests for ppr_router.
 * Assumes the pad model closes the pin loop and the checker is bound.
 */
`timescale 1ns/1ps
module ppr_router_tb
    import ppr_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [7:0] pat = 8'h00;
    logic [5:0][7:0] padLevel = 48'h3c_a5_69_96_5a_c3;
    logic [7:0] regRdData;
    logic [3:0][3:0] xcvrIn;
    logic dual = 1'b1;
    logic [1:0] hostIn;
    logic [1:0] clientIn;
    logic [3:0] spiIn;
    logic [5:0][7:0] pinIn;
    logic [5:0][7:0] pinOwn;
    logic [5:0][7:0] pinOut;
    logic [5:0][7:0] pinOeN;
    logic [7:0] g;
    logic [3:0] e;
    int badCount = 0;
    int comparisons = 0;
    int cycles = 0;
    int p;
    int b;
    logic [7:0] mask [7] = '{8'h0d, 8'h0f, 8'hff, 8'h33, 8'h07, 8'h0f, 8'h00};
    logic [7:0] xv [4] = '{8'h55, 8'h00, 8'hff, 8'haa};

    // peripheral outputs come from a running count so each driven pin sees motion
    ppr_router u_ppr_router
    (
        .clock, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
        .eventOut(pat[5:0]), .tableOut(pat[6:3]), .xcvrOut({4{pat[3:0]}}),
        .xcvrOe(16'h0000), .xcvrIn, .dualTwoWire(dual), .twoWireHostOeN(pat[1:0]),
        .twoWireHostIn(hostIn), .twoWireClientOeN(pat[2:1]), .twoWireClientIn(clientIn),
        .spiOut(pat[3:0]), .spiOe(4'hf), .spiIn(spiIn), .waveOut(pat[7:2]),
        .timer2Out(pat[7]), .timer3Out(pat[6]), .pinIn, .pinOwn, .pinOut, .pinOeN
    );
    ppr_pad_model u_ppr_pad_model
    (
        .pinOwn, .pinOut, .pinOeN, .padLevel, .pinIn
    );

    always #50 clock = ~clock;
    always @(posedge clock)
    begin
        pat <= pat + 8'h01;
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            badCount++;
            testDone();
        end
    end

    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrStb <= w;
        regRdStb <= !w;
        regAddr <= a;
        regWrData <= d;
    endtask : acc

    // results are sampled mid-cycle, clear of the launching edge
    task idle;
        @(posedge clock);
        regWrStb <= 1'b0;
        regRdStb <= 1'b0;
        @(negedge clock);
    endtask : idle

    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            badCount++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task testDone;
        if (badCount == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : testDone

    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b0, 8'(i), 8'h00);
            idle();
            chk(regRdData, 8'h00);
        end
        for (int i = 0; i < 7; i++)
        begin
            // event b, e, f alternates stay clear, they are reserved
            acc(1'b1, 8'(i), (i == 0) ? 8'hcd : 8'hff);
            acc(1'b0, 8'(i), 8'h00);
            idle();
            chk(regRdData, mask[i]);
        end
        acc(1'b1, EVENT_OUTPUT_ROUTE_OFS, 8'h0d);
        idle();
        g = {3'h0, pinOut[3][7], pinOut[2][7], pinOut[0][7], pinOwn[3][2], pinOwn[1][2]};
        chk(g, {3'h0, pat[3], pat[2], pat[0], 2'b01});
        for (int v = 0; v < 2; v++)
        begin
            acc(1'b1, LOGIC_TABLE_ROUTE_OFS, v ? 8'h00 : 8'h0f);
            idle();
            b = v ? 3 : 6;
            g = {pinOut[5][b], pinOut[3][b], pinOut[2][b], pinOut[0][b],
                pinOwn[5][9 - b], pinOwn[3][9 - b], pinOwn[2][9 - b], pinOwn[0][9 - b]};
            chk(g, {pat[6:3], 4'h0});
            acc(1'b1, CAPTURE_TIMER_ROUTE_OFS, v ? 8'h00 : 8'h0c);
            idle();
            g = {2'h0, pinOwn[2][1], pinOwn[1][5], pinOwn[1][4], pinOwn[2][0],
                pinOut[2][1] | pinOut[1][5], pinOut[1][4] | pinOut[2][0]};
            chk(g, {2'h0, v ? 4'h5 : 4'ha, pat[6], pat[7]});
        end
        for (int k = 0; k < 4; k++)
        begin
            // timers parked off the lanes under test, else they drive them
            g = (k == 0) ? 8'h08 : (k == 1) ? 8'h04 : 8'h00;
            acc(1'b1, CAPTURE_TIMER_ROUTE_OFS, g);
            acc(1'b1, SERIAL_TRANSCEIVER_ROUTE_OFS, xv[k]);
            idle();
            // pin levels need two sync stages
            repeat (2) @(negedge clock);
            for (int n = 0; n < 4; n++)
            begin
                p = XCVR_PORT[n];
                e = (padLevel[p][7:4] & XCVR_ALT_LANES[n]) | ~XCVR_ALT_LANES[n];
                if (xv[k] != 8'h55)
                    e = (xv[k] == 8'h00) ? padLevel[p][3:0] : 4'hf;
                g = {pinOwn[p][1], pinOwn[p][4], 2'h0, xcvrIn[n]};
                chk(g, {k == 1 || (k == 0 && p == PORT_C), k == 0 || (k == 1 && p == PORT_B),
                    2'h0, e});
            end
        end
        for (int v = 0; v < 3; v++)
        begin
            acc(1'b1, TWO_WIRE_AND_SPI_ROUTE_OFS, 8'(v * 17));
            idle();
            p = (v == 2) ? PORT_C : PORT_A;
            b = (v == 0) ? PORT_C : PORT_F;
            g = {pinOeN[p][3:2], pinOeN[b][3:2], pinOut[p][3:2], pinOut[b][3:2]};
            chk(g, {pat[1:0], pat[2:1], 4'h0});
            p = (v == 0) ? PORT_A : (v == 1) ? PORT_C : PORT_E;
            b = (v == 0) ? 4 : 0;
            chk({3'h0, pinOut[p][b + 1], pinOwn[p][b +: 4]}, {3'h0, pat[1], 4'hf});
        end
        // without dual mode the client pair hands its pins back
        @(posedge clock);
        dual <= 1'b0;
        @(negedge clock);
        chk({4'h0, clientIn, pinOut[5][3:2]}, {4'h0, 2'b11, pat[6], pat[5]});
        acc(1'b1, TWO_WIRE_AND_SPI_ROUTE_OFS, 8'h33);
        idle();
        g = {pinOwn[0][2], pinOwn[2][2], pinOwn[4][3], pinOwn[4][1], pinOwn[0][6:4], pinOwn[2][1]};
        chk(g, 8'h00);
        chk({hostIn, clientIn, spiIn}, 8'hff);
        for (int v = 0; v < 7; v++)
        begin
            acc(1'b1, WAVEFORM_TIMER_ROUTE_OFS, 8'(v));
            idle();
            if (v < 6)
                chk({4'h0, pinOut[v][4:1]}, {4'h0, pat[6:3]});
            else
                chk({3'h0, pinOwn[3][5:4], pinOwn[3][2:0]}, 8'h00);
        end
        testDone();
    end
endmodule : ppr_router_tb
